/* src/ceq_top.v */
`timescale 1ns/1ps
// Overview of operation
// RL1 - Wait code selects 0 s, then 1..64 s doubling
// RL2 - Mode field: off, manual, timed, auto
// RL3 - Setting enable starts the selected mode
// RL4 - Enable set by register write or command
// RL5 - Manual mode outputs follow pattern directly
// RL6 - Timed mode turns all outputs off after duration
// RL7 - Auto mode removes charge over several cycles
// RL8 - Select bit n drives cell n+1 output
// RL9 - Set bit enables cell, clear bit keeps off
// RL10 - Thirteen pattern instances, pointer picks one
// RL11 - Instance zero drives manual and timed modes
// RL12 - Instances one to twelve form auto sequence
// RL13 - Auto mode advances pointer every cycle
// RL14 - Zero pattern wraps pointer back to one
// RL15 - Setup register layout at index 13h
// RL16 - Cell select register at index 14h
// RL17 - Twelve outputs controlled independently
// RL18 - Clear enable or inhibit command stops equalizing
// RL19 - Off mode or clear enable holds outputs off
// RL20 - Host sets pointer before pattern access
`include "ceq_consts.vh"

module ceq_top #(
  parameter TICK_CYCLES = `CEQ_TICK_CYCLES,
  parameter CNT_W       = 28
) (
  // Clock and reset
  input  wire                  clk_sys,
  input  wire                  sys_rst,
  // APB slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [7:0]            paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  // Balancing transistor drives, bit 0 is cell 1
  output reg  [`CEQ_CELLS-1:0] cell_fet_drive_q
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_LOAD = 4'h2;
  localparam [3:0] ST_ON   = 4'h4;
  localparam [3:0] ST_WAIT = 4'h8;
  // Divider end count, cut to the counter width on purpose
  localparam [31:0]      TICK_SPAN = TICK_CYCLES - 1;
  localparam [CNT_W-1:0] TICK_LAST = TICK_SPAN[CNT_W-1:0];

  reg  [`CEQ_SETUP_W-1:0]   setup_q;
  reg  [`CEQ_ON_TIME_W-1:0] on_time_q;
  reg                       done_q;
  reg  [3:0]                state_q;
  reg  [3:0]                state_d;
  reg  [1:0]                run_mode_q;
  reg  [1:0]                load_wait_q;
  reg  [CNT_W-1:0]          div_q;
  reg                       tick_q;
  reg  [`CEQ_SEC_W-1:0]     sec_q;
  reg  [`CEQ_SEC_W-1:0]     sec_d;
  reg  [`CEQ_PTR_W-1:0]     ptr_d;
  reg                       en_clr;
  reg                       done_set;
  reg  [`CEQ_CELLS-1:0]     fet_d;
  reg  [31:0]               rdata_d;

  wire [1:0]                mode;
  wire [2:0]                wait_sel;
  wire [`CEQ_PTR_W-1:0]     ptr;
  wire                      en;
  wire [`CEQ_CELLS-1:0]     pat_host;
  wire [`CEQ_CELLS-1:0]     pat_run;
  wire [`CEQ_PTR_W-1:0]     run_addr;
  wire [5:0]                idx;
  wire                      acc;
  wire                      wr_done;
  wire                      hit;
  wire [`CEQ_SEC_W-1:0]     on_secs;
  wire [`CEQ_SEC_W-1:0]     wait_secs;
  wire [31:0]               on_prod;

  ////////////////////////////////////////////////////////////////////////
  // Field decode

  // Setup register fields; pointer is split over bits 8 and 7:5
  assign mode     = setup_q[`CEQ_MODE_LSB +: 2];                 // [RL15]
  assign wait_sel = setup_q[`CEQ_WAIT_LSB +: 3];                 // [RL15]
  assign ptr      = {setup_q[`CEQ_PTR_HI_BIT],
                     setup_q[`CEQ_PTR_LO_LSB +: 3]};             // [RL15]
  assign en       = setup_q[`CEQ_EN_BIT];                        // [RL15]

  // Wait code to seconds: 0 gives none, else doubles from 1 s
  function [`CEQ_SEC_W-1:0] wait_to_secs;
    input [2:0] code;
    begin
      if (code == 3'h0)
        wait_to_secs = {`CEQ_SEC_W{1'b0}};
      else
        wait_to_secs = {{(`CEQ_SEC_W-1){1'b0}}, 1'b1} << (code - 3'h1);
    end
  endfunction

  assign wait_secs = wait_to_secs(wait_sel);                     // [RL1]
  // On-time in 20 s steps; 127 steps fit in twelve bits
  assign on_prod   = on_time_q * `CEQ_STEP_S;
  assign on_secs   = on_prod[`CEQ_SEC_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // APB decode

  // Word-aligned index; one wait state so read data leaves a register
  assign idx     = paddr[7:2];
  assign acc     = psel && penable;
  assign wr_done = acc && pready && pwrite;
  assign hit     = (paddr[1:0] == 2'h0) &&
                   ((idx == `CEQ_IDX_SETUP) || (idx == `CEQ_IDX_CELL_SEL) ||
                    (idx == `CEQ_IDX_ON_TIME) || (idx == `CEQ_IDX_STATUS) ||
                    (idx == `CEQ_IDX_COMMAND));

  // Read mux; cell select shows only the pointed instance
  always @* begin
    rdata_d = 32'h0000_0000;
    case (idx)
      `CEQ_IDX_SETUP:
        rdata_d[`CEQ_SETUP_W-1:0] = setup_q;
      `CEQ_IDX_CELL_SEL:
        rdata_d[`CEQ_CELLS-1:0] = pat_host;                      // [RL10]
      `CEQ_IDX_ON_TIME:
        rdata_d[`CEQ_ON_TIME_W-1:0] = on_time_q;
      `CEQ_IDX_STATUS: begin
        rdata_d[`CEQ_STAT_ACTIVE] = (state_q != ST_IDLE);
        rdata_d[`CEQ_STAT_DONE]   = done_q;
        rdata_d[`CEQ_STAT_FET_LSB +: `CEQ_CELLS] = cell_fet_drive_q;
      end
      default:
        rdata_d = 32'h0000_0000;
    endcase
  end

  // Bus handshake: ready one cycle into the access phase
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (acc && !pready) begin
      pready  <= 1'b1;
      pslverr <= !hit;
      prdata  <= (hit && !pwrite) ? rdata_d : 32'h0000_0000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern store

  // Host port sees the pointed instance; run port sees the active one
  assign run_addr = (run_mode_q == `CEQ_MODE_AUTO) ? ptr :
                    `CEQ_PTR_MANUAL;                             // [RL11]

  ceq_pattern_mem #(
    .WIDTH (`CEQ_CELLS),
    .DEPTH (`CEQ_INSTANCES),
    .AW    (`CEQ_PTR_W)
  ) u_mem (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .wr_en     (wr_done && (idx == `CEQ_IDX_CELL_SEL) && hit),   // [RL16]
    .wr_addr   (ptr),                                            // [RL10]
    .wr_data   (pwdata[`CEQ_CELLS-1:0]),
    .rd_a_addr (ptr),
    .rd_a_q    (pat_host),
    .rd_b_addr (run_addr),
    .rd_b_q    (pat_run)
  );

  ////////////////////////////////////////////////////////////////////////
  // Setup, on-time and done registers

  // Software writes win over the engine's pointer and enable updates
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      setup_q   <= `CEQ_SETUP_RST;
      on_time_q <= `CEQ_ON_TIME_RST;
    end else if (wr_done && hit && (idx == `CEQ_IDX_SETUP)) begin
      setup_q <= pwdata[`CEQ_SETUP_W-1:0];                       // [RL4]
    end else if (wr_done && hit && (idx == `CEQ_IDX_ON_TIME)) begin
      on_time_q <= pwdata[`CEQ_ON_TIME_W-1:0];
    end else if (wr_done && hit && (idx == `CEQ_IDX_COMMAND)) begin
      // Inhibit outranks enable when both are written together
      if (pwdata[`CEQ_CMD_INHIBIT])
        setup_q[`CEQ_EN_BIT] <= 1'b0;                            // [RL18]
      else if (pwdata[`CEQ_CMD_ENABLE])
        setup_q[`CEQ_EN_BIT] <= 1'b1;                            // [RL4]
    end else begin
      {setup_q[`CEQ_PTR_HI_BIT], setup_q[`CEQ_PTR_LO_LSB +: 3]} <= ptr_d;
      if (en_clr)
        setup_q[`CEQ_EN_BIT] <= 1'b0;
    end
  end

  // Done flag: timed run completion sets, write one clears, set wins
  always @(posedge clk_sys) begin
    if (sys_rst)
      done_q <= 1'b0;
    else if (done_set)
      done_q <= 1'b1;
    else if (wr_done && hit && (idx == `CEQ_IDX_STATUS) &&
             pwdata[`CEQ_STAT_DONE])
      done_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One-second time base

  // Restarted when idle so every run gets whole seconds
  always @(posedge clk_sys) begin
    if (sys_rst || (state_q == ST_IDLE) || (div_q == TICK_LAST)) begin
      div_q <= {CNT_W{1'b0}};
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst)
      tick_q <= 1'b0;
    else
      tick_q <= (state_q != ST_IDLE) && (div_q == TICK_LAST);
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next state; a mode change or enable drop always lands in idle
  always @* begin
    state_d  = state_q;
    sec_d    = tick_q ? sec_q + 1'b1 : sec_q;
    ptr_d    = ptr;
    en_clr   = 1'b0;
    done_set = 1'b0;
    if (!en || (mode == `CEQ_MODE_OFF) || (mode != run_mode_q)) begin
      state_d = ST_IDLE;                                         // [RL18]
      sec_d   = {`CEQ_SEC_W{1'b0}};
    end else begin
      case (state_q)
        ST_IDLE: begin
          sec_d = {`CEQ_SEC_W{1'b0}};
          if (mode == `CEQ_MODE_AUTO) begin
            ptr_d   = `CEQ_PTR_FIRST;                            // [RL12]
            state_d = ST_LOAD;                                   // [RL3]
          end else begin
            state_d = ST_ON;                                     // [RL3]
          end
        end
        ST_LOAD: begin
          // Registered read needs two cycles to show the new instance
          sec_d = {`CEQ_SEC_W{1'b0}};
          if (load_wait_q == 2'h0) begin
            if ((pat_run == {`CEQ_CELLS{1'b0}}) &&
                (ptr != `CEQ_PTR_FIRST)) begin
              ptr_d = `CEQ_PTR_FIRST;                            // [RL14]
            end else begin
              state_d = ST_ON;
            end
          end
        end
        ST_ON: begin
          // Manual never ends on its own; zero on-time means no limit
          if ((run_mode_q != `CEQ_MODE_MANUAL) && (|on_time_q) &&
              (sec_q >= on_secs)) begin
            sec_d = {`CEQ_SEC_W{1'b0}};
            if (run_mode_q == `CEQ_MODE_TIMED) begin
              en_clr   = 1'b1;                                   // [RL6]
              done_set = 1'b1;
              state_d  = ST_IDLE;
            end else begin
              state_d = ST_WAIT;                                 // [RL7]
            end
          end
        end
        ST_WAIT: begin
          if (sec_q >= wait_secs) begin                          // [RL1]
            sec_d   = {`CEQ_SEC_W{1'b0}};
            ptr_d   = (ptr == `CEQ_PTR_LAST) ? `CEQ_PTR_FIRST :
                      ptr + 1'b1;                                // [RL13]
            state_d = ST_LOAD;
          end
        end
        default: begin
          state_d = ST_IDLE;
          sec_d   = {`CEQ_SEC_W{1'b0}};
        end
      endcase
    end
  end

  // State, mode capture and load delay
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      run_mode_q  <= `CEQ_MODE_OFF;
      sec_q       <= {`CEQ_SEC_W{1'b0}};
      load_wait_q <= 2'h0;
    end else begin
      state_q    <= state_d;
      sec_q      <= sec_d;
      run_mode_q <= mode;                                        // [RL2]
      if ((state_d == ST_LOAD) && (ptr_d != ptr || state_q != ST_LOAD))
        load_wait_q <= 2'h2;
      else if (load_wait_q != 2'h0)
        load_wait_q <= load_wait_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transistor drives

  // Each bit drives its own cell; off unless enabled and on phase
  always @* begin
    fet_d = {`CEQ_CELLS{1'b0}};                                  // [RL19]
    if (en && (mode != `CEQ_MODE_OFF) && (state_q == ST_ON) &&
        (run_mode_q == mode))
      fet_d = pat_run;                              // [RL5] [RL8] [RL9]
  end

  always @(posedge clk_sys) begin
    if (sys_rst)
      cell_fet_drive_q <= {`CEQ_CELLS{1'b0}};
    else
      cell_fet_drive_q <= fet_d;                                 // [RL17]
  end

endmodule // ceq_top

/* src/ceq_consts.vh */
`ifndef CEQ_CONSTS_VH
`define CEQ_CONSTS_VH

// Register indexes (byte address is four times the index)
`define CEQ_IDX_SETUP      6'h13
`define CEQ_IDX_CELL_SEL   6'h14
`define CEQ_IDX_ON_TIME    6'h15
`define CEQ_IDX_STATUS     6'h16
`define CEQ_IDX_COMMAND    6'h17

// Setup register fields
`define CEQ_SETUP_W        10
`define CEQ_MODE_LSB       0
`define CEQ_WAIT_LSB       2
`define CEQ_PTR_LO_LSB     5
`define CEQ_PTR_HI_BIT     8
`define CEQ_EN_BIT         9
`define CEQ_SETUP_RST      10'h000

// Mode encodings
`define CEQ_MODE_OFF       2'h0
`define CEQ_MODE_MANUAL    2'h1
`define CEQ_MODE_TIMED     2'h2
`define CEQ_MODE_AUTO      2'h3

// Cell patterns
`define CEQ_CELLS          12
`define CEQ_INSTANCES      13
`define CEQ_PTR_W          4
`define CEQ_PTR_FIRST      4'h1
`define CEQ_PTR_LAST       4'hC
`define CEQ_PTR_MANUAL     4'h0

// On-time register, status and command bits
`define CEQ_ON_TIME_W      7
`define CEQ_ON_TIME_RST    7'h00
`define CEQ_STEP_S         20
`define CEQ_STAT_ACTIVE    0
`define CEQ_STAT_DONE      1
`define CEQ_STAT_FET_LSB   4
`define CEQ_CMD_ENABLE     0
`define CEQ_CMD_INHIBIT    1

// Time base: one second at a 200 MHz clock
`define CEQ_CLK_HZ         200000000
`define CEQ_TICK_S         1
`define CEQ_TICK_CYCLES    (`CEQ_TICK_S * `CEQ_CLK_HZ)
`define CEQ_SEC_W          12

`endif

/* src/ceq_pattern_mem.v */
`timescale 1ns/1ps
// Multiple-instance cell pattern store, two registered read ports
module ceq_pattern_mem #(
  parameter WIDTH = 12,
  parameter DEPTH = 13,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             sys_rst,
  // Write port
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  // Read ports
  input  wire [AW-1:0]    rd_a_addr,
  output reg  [WIDTH-1:0] rd_a_q,
  input  wire [AW-1:0]    rd_b_addr,
  output reg  [WIDTH-1:0] rd_b_q
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  genvar g;

  // Storage words; out-of-range addresses never write
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_word
      always @(posedge clk_sys) begin
        if (sys_rst)
          mem_q[g] <= {WIDTH{1'b0}};
        else if (wr_en && (wr_addr == g))
          mem_q[g] <= wr_data;
      end
    end
  endgenerate

  // Registered reads; an empty location reads as zero
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_a_q <= {WIDTH{1'b0}};
      rd_b_q <= {WIDTH{1'b0}};
    end else begin
      rd_a_q <= (rd_a_addr < DEPTH) ? mem_q[rd_a_addr] : {WIDTH{1'b0}};
      rd_b_q <= (rd_b_addr < DEPTH) ? mem_q[rd_b_addr] : {WIDTH{1'b0}};
    end
  end
endmodule // ceq_pattern_mem

/* bench/ceq_top_asserts.sv */
`timescale 1ns/1ps
module ceq_top_asserts #(
  parameter TICK_CYCLES = 10,
  parameter CNT_W       = 28
) (
  // Clock and reset
  input wire        clk_sys,
  input wire        sys_rst,
  // APB slave
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Transistor drives
  input wire [11:0] cell_fet_drive_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Mapped words are indexes 13h..17h, aligned
  wire map_ok = paddr[7:2] >= 6'h13 && paddr[7:2] <= 6'h17 && !paddr[1:0];
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_off;
    pready && pwrite && paddr == 8'h4C && (!pwdata[1:0] || !pwdata[9]);
  endsequence
  sequence s_inh;
    pready && pwrite && paddr == 8'h5C && pwdata[1];
  endsequence
  a_ready_one_wait: assert property (s_wait |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_unmapped: assert property (pready && !map_ok |-> pslverr && !prdata)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && map_ok |-> !pslverr)
    else $error("mapped access refused");
  a_mode_off_stops: assert property (s_off |=> ##1 !cell_fet_drive_q)
    else $error("drives on after off or enable clear");
  a_inhibit_stops: assert property (s_inh |=> ##1 !cell_fet_drive_q)
    else $error("drives on after inhibit");
  a_setup_width: assert property (pready && paddr == 8'h4C |-> !prdata[31:10])
    else $error("setup read wider than ten bits");
  a_select_width: assert property (pready && paddr == 8'h50 |-> !prdata[31:12])
    else $error("select read wider than twelve bits");
endmodule // ceq_top_asserts

bind ceq_top ceq_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .CNT_W(CNT_W)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cell_fet_drive_q(cell_fet_drive_q));

/* bench/ceq_fet_bank.sv */
`timescale 1ns/1ps
module ceq_fet_bank (
  // Gate drives, bit 0 is cell 1
  input  wire [11:0] gate,
  // Number of bypass paths conducting
  output reg  [3:0]  on_cnt
);
  integer k;
  // Each gate owns one path; no coupling, so any mix may conduct
  always @* begin
    on_cnt = 4'h0;
    for (k = 0; k < 12; k = k + 1) on_cnt = on_cnt + {3'h0, gate[k]};
  end
endmodule // ceq_fet_bank

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  reg         clk_sys, sys_rst, psel, penable, pwrite, re;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rv;
  wire [31:0] prdata;
  wire        pready, pslverr;
  wire [11:0] drv;
  wire [3:0]  on_cnt;
  integer     fails, checked, i, n;
  localparam SU = 8'h4C, CS = 8'h50, OT = 8'h54, ST = 8'h58, CM = 8'h5C;
  // Short second so timed and auto runs stay brief
  ceq_top #(.TICK_CYCLES(10), .CNT_W(28)) i_ceq_top (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cell_fet_drive_q(drv));
  ceq_fet_bank i_ceq_fet_bank (.gate(drv), .on_cnt(on_cnt));
  ////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task wrap_up; begin
    $display("Counts: checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  task chk(input [31:0] got, input [31:0] exp); begin
    checked = checked + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  end endtask
  // One APB transfer; request held until pready is seen high
  task apb(input [7:0] a, input w, input [31:0] d); begin
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n = n + 1;
    end
    chk({31'h0, n < 20}, 32'h1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  end endtask
  task wr(input [7:0] a, input [31:0] d); apb(a, 1'b1, d); endtask
  task rd(input [7:0] a, input [31:0] e); begin
    apb(a, 1'b0, 32'h0);
    chk({31'h0, re}, 32'h0);
    chk(rv, e);
  end endtask
  // Bounded wait for a drive pattern; n returns cycles spent
  task wait_drv(input [11:0] e, input integer lim); begin
    n = 0;
    while (drv !== e && n < lim) begin
      @(posedge clk_sys);
      n = n + 1;
    end
    chk({20'h0, drv}, {20'h0, e});
  end endtask
  task run_man(input [11:0] p, input [3:0] c); begin
    wr(SU, 32'h0);
    wr(CS, {20'h0, p});
    wr(SU, 32'h201);
    // Mode change costs one idle cycle before the on phase
    repeat (4) @(posedge clk_sys);
    chk({20'h0, drv}, {20'h0, p});
    chk({28'h0, on_cnt}, {28'h0, c});
  end endtask
  function [31:0] pat(input integer k);
    pat = (32'hA5C ^ (k * 32'h111)) & 32'hFFF;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; fails = 0; checked = 0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(SU, 32'h0);
    rd(CS, 32'h0);
    apb(8'h00, 1'b0, 32'h0);
    chk({31'h0, re}, 32'h1);
    apb(8'h4D, 1'b1, 32'h3FF);
    chk({31'h0, re}, 32'h1);
    wr(SU, 32'h194);
    rd(SU, 32'h194);
    $display("Test registers done");
    for (i = 0; i < 13; i = i + 1) begin
      wr(SU, i << 5);
      wr(CS, pat(i));
    end
    for (i = 0; i < 13; i = i + 1) begin
      wr(SU, i << 5);
      rd(CS, pat(i));
    end
    $display("Test instances done");
    for (i = 0; i < 12; i = i + 1) run_man(12'h001 << i, 4'h1);
    run_man(12'hFFF, 4'hC);
    wr(SU, 32'h200);
    repeat (3) @(posedge clk_sys);
    chk({20'h0, drv}, 32'h0);
    wr(SU, 32'h201);
    wr(CM, 32'h2);
    repeat (3) @(posedge clk_sys);
    chk({20'h0, drv}, 32'h0);
    rd(SU, 32'h001);
    wr(CM, 32'h1);
    wait_drv(12'hFFF, 5);
    rd(SU, 32'h201);
    wr(SU, 32'h001);
    repeat (3) @(posedge clk_sys);
    chk({20'h0, drv}, 32'h0);
    $display("Test manual done");
    wr(SU, 32'h0);
    wr(CS, 32'h0C3);
    wr(OT, 32'h1);
    wr(SU, 32'h202);
    wait_drv(12'h0C3, 10);
    wait_drv(12'h0, 300);
    chk({31'h0, n > 190 && n < 206}, 32'h1);
    apb(ST, 1'b0, 32'h0);
    chk({31'h0, rv[1]}, 32'h1);
    rd(SU, 32'h002);
    wr(ST, 32'h2);
    rd(ST, 32'h0);
    $display("Test timed done");
    wr(SU, 3 << 5);
    wr(CS, 32'h0);
    wr(SU, 32'h20B);
    wait_drv(pat(1), 10);
    wait_drv(12'h0, 250);
    wait_drv(pat(2), 40);
    chk({31'h0, n > 17 && n < 24}, 32'h1);
    wait_drv(12'h0, 250);
    wait_drv(pat(1), 40);
    wr(SU, 32'h0);
    wr(SU, 32'h203);
    wait_drv(pat(1), 10);
    wait_drv(12'h0, 250);
    wait_drv(pat(2), 10);
    chk({31'h0, n < 8}, 32'h1);
    $display("Test auto done");
    wrap_up;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails = fails + 1;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule // testbench
